// ---- rsm_top.sv ----
// reset status, retention control and boot memory remap
//
// Overview of operation
// - any reset returns flash to address zero
// - remap bit set mirrors sram at zero
// - remap bit cleared restores flash at zero
// - swapped window covers the exception vectors
// - boot pin high runs config then branches
// - bit 4 flags reduced flash, read only
// - bit 3 flags reduced sram, read only
// - bits 2:1 choose debug or gpio pins
// - pin function loaded from strap each reset
// - four reset causes are distinguished
// - all-zero status means external reset
// - writing status bit 2 forces software reset
// - watchdog reset sets status bit 1
// - power-on sets status bit 0
// - status cleared only through clear register
// - config bit 0 keeps gpio through watchdog and software resets
// - dac retain bit keeps dac through watchdog and software resets
// - dac retain sits at config bit 2
// - config written between first and second key
`timescale 1ns/100ps
`default_nettype none
module rsm_top #(
    parameter int CONFIG_LEN = rsm_pkg::CONFIG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [rsm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [rsm_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [rsm_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic ext_reset_in,
    input wire logic wdt_timeout_in,
    input wire logic boot_mode_pin_in,
    input wire logic boot_strap_pin_in,
    input wire logic flash_reduced_in,
    input wire logic sram_reduced_in,
    input wire logic [rsm_pkg::ADDR_W-1:0] cpu_addr_in,
    output logic soft_reset_req_out,
    output logic core_hold_out,
    output logic kernel_mode_out,
    output logic [rsm_pkg::ADDR_W-1:0] boot_vector_out,
    output logic mirror_sram_out,
    output logic vector_from_sram_out,
    output logic [1:0] debug_pin_function_out,
    output logic gpio_retain_out,
    output logic dac_retain_out,
    output logic gpio_reset_out,
    output logic dac_reset_out
);
    import rsm_pkg::*;

    localparam logic [7:0] CFG_LAST = 8'(CONFIG_LEN - 1);

    typedef struct packed {
        logic remap;
        logic [1:0] pin_fn;
        logic flash_small;
        logic sram_small;
        logic [2:0] cause;
        logic [7:0] clear_val;
        logic [31:0] rdata;
        rsm_boot_type boot;
        logic [7:0] cnt;
        logic soft_req;
        logic gpio_rst;
        logic dac_rst;
        logic sram_sel;
        logic hold;
        logic kernel;
        logic [31:0] vector;
    } rsm_top_state_type;

    rsm_top_state_type q;
    rsm_top_state_type d;

    rsm_cfg_if cfg_bus ();

    logic wr_map;
    logic wr_cause;
    logic wr_clear;
    logic soft_hit;
    logic sys_reset;
    logic warm_reset;
    logic [7:0] map_view;
    logic in_vectors;

    rsm_key_seq u_key (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .bus(cfg_bus.keyer)
    );

    assign cfg_bus.wr = reg_wr_in;
    assign cfg_bus.addr = reg_addr_in;
    assign cfg_bus.wdata = reg_wdata_in[7:0];

    assign wr_map = reg_wr_in && (reg_addr_in == MAP_SEL_ADDR);
    assign wr_cause = reg_wr_in && (reg_addr_in == CAUSE_STATUS_ADDR);
    assign wr_clear = reg_wr_in && (reg_addr_in == CAUSE_CLEAR_ADDR);
    assign soft_hit = wr_cause && reg_wdata_in[CAUSE_SOFT_BIT];
    // external, watchdog and software resets all restart the boot sequence
    assign sys_reset = ext_reset_in || wdt_timeout_in || soft_hit;
    // only watchdog and software resets honour the retention configuration
    assign warm_reset = wdt_timeout_in || soft_hit;
    assign in_vectors = (cpu_addr_in >= VECTOR_LO_ADDR) && (cpu_addr_in <= VECTOR_HI_ADDR);

    always_comb begin
        map_view = 8'h00;
        map_view[MAP_REMAP_BIT] = q.remap;
        map_view[MAP_PINFN_LSB +: 2] = q.pin_fn;
        map_view[MAP_SRAM_SMALL_BIT] = q.sram_small;
        map_view[MAP_FLASH_SMALL_BIT] = q.flash_small;
    end

    always_comb begin
        d = q;
        d.soft_req = 1'b0;
        d.gpio_rst = 1'b0;
        d.dac_rst = 1'b0;

        // register writes; size and pin function bits ignore software
        if (wr_map) begin
            d.remap = reg_wdata_in[MAP_REMAP_BIT];
        end
        if (wr_clear) begin
            d.clear_val = reg_wdata_in[7:0];
        end

        // clear first, then set, so a cause arriving with its clear survives
        if (wr_clear) begin
            d.cause = q.cause & ~reg_wdata_in[2:0];
        end
        if (wdt_timeout_in) begin
            d.cause[CAUSE_WDT_BIT] = 1'b1;
        end
        if (soft_hit) begin
            d.cause[CAUSE_SOFT_BIT] = 1'b1;
            d.soft_req = 1'b1;
        end
        // an external reset leaves the causes alone, so none set reads as external

        if (sys_reset) begin
            d.remap = 1'b0;
            d.boot = BOOT_HOLD;
            d.cnt = 8'h00;
            d.gpio_rst = !(warm_reset && cfg_bus.cfg[CFG_GPIO_BIT]);
            d.dac_rst = !(warm_reset && cfg_bus.cfg[CFG_DAC_BIT]);
        end else begin
            case (q.boot)
                BOOT_HOLD: begin
                    // strap and size levels are caught here, one cycle after the release
                    d.pin_fn = boot_strap_pin_in ? PINFN_GPIO : PINFN_DEBUG;
                    d.flash_small = flash_reduced_in;
                    d.sram_small = sram_reduced_in;
                    d.cnt = 8'h00;
                    d.boot = boot_mode_pin_in ? BOOT_CONFIG : BOOT_KERNEL;
                end
                BOOT_CONFIG: begin
                    if (q.cnt == CFG_LAST) begin
                        d.boot = BOOT_RUN;
                    end else begin
                        d.cnt = q.cnt + 8'h01;
                    end
                end
                BOOT_RUN: begin
                    d.boot = BOOT_RUN;
                end
                BOOT_KERNEL: begin
                    // download mode: the core stays in the hidden kernel
                    d.boot = BOOT_KERNEL;
                end
                default: begin
                    d.boot = BOOT_HOLD;
                end
            endcase
        end

        // the window decode is registered, so a fetch sees it one cycle late
        d.sram_sel = d.remap && in_vectors;
        // boot status is decoded ahead of the flop so the pins never glitch on a state change
        d.hold = (d.boot != BOOT_RUN);
        d.kernel = (d.boot == BOOT_KERNEL);
        d.vector = USER_RESET_VECTOR;

        d.rdata = 32'h00000000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                MAP_SEL_ADDR: d.rdata = {24'h000000, map_view};
                CAUSE_STATUS_ADDR: d.rdata = {29'h0, q.cause};
                CAUSE_CLEAR_ADDR: d.rdata = {24'h000000, q.clear_val};
                RETAIN_CFG_ADDR: d.rdata = {24'h000000, cfg_bus.cfg};
                default: d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q.remap <= 1'b0;
            q.pin_fn <= PINFN_DEBUG;
            q.flash_small <= 1'b0;
            q.sram_small <= 1'b0;
            q.cause <= CAUSE_RESET_VAL;
            q.clear_val <= CLEAR_RESET_VAL;
            q.rdata <= 32'h00000000;
            q.boot <= BOOT_HOLD;
            q.cnt <= 8'h00;
            q.soft_req <= 1'b0;
            q.gpio_rst <= 1'b1;
            q.dac_rst <= 1'b1;
            q.sram_sel <= 1'b0;
            q.hold <= 1'b1;
            q.kernel <= 1'b0;
            q.vector <= USER_RESET_VECTOR;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign soft_reset_req_out = q.soft_req;
    assign core_hold_out = q.hold;
    assign kernel_mode_out = q.kernel;
    assign boot_vector_out = q.vector;
    assign mirror_sram_out = q.remap;
    assign vector_from_sram_out = q.sram_sel;
    assign debug_pin_function_out = q.pin_fn;
    assign gpio_retain_out = cfg_bus.cfg[CFG_GPIO_BIT];
    assign dac_retain_out = cfg_bus.cfg[CFG_DAC_BIT];
    assign gpio_reset_out = q.gpio_rst;
    assign dac_reset_out = q.dac_rst;
endmodule
`default_nettype wire

// ---- rsm_pkg.sv ----
// shared constants and types of the reset status and memory remap block
package rsm_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // register byte addresses
    localparam logic [31:0] MAP_SEL_ADDR = 32'hffff0220;
    localparam logic [31:0] CAUSE_STATUS_ADDR = 32'hffff0230;
    localparam logic [31:0] CAUSE_CLEAR_ADDR = 32'hffff0234;
    localparam logic [31:0] UNLOCK_FIRST_ADDR = 32'hffff0248;
    localparam logic [31:0] RETAIN_CFG_ADDR = 32'hffff024c;
    localparam logic [31:0] UNLOCK_SECOND_ADDR = 32'hffff0250;

    // memory_map_select fields
    localparam int MAP_REMAP_BIT = 0;
    localparam int MAP_PINFN_LSB = 1;
    localparam int MAP_SRAM_SMALL_BIT = 3;
    localparam int MAP_FLASH_SMALL_BIT = 4;
    localparam logic [1:0] PINFN_DEBUG = 2'h0;
    localparam logic [1:0] PINFN_GPIO = 2'h2;

    // reset_cause_status fields
    localparam int CAUSE_POR_BIT = 0;
    localparam int CAUSE_WDT_BIT = 1;
    localparam int CAUSE_SOFT_BIT = 2;
    localparam logic [2:0] CAUSE_RESET_VAL = 3'h1;
    localparam logic [7:0] CLEAR_RESET_VAL = 8'h00;

    // reset_retention_config fields and keys
    localparam int CFG_GPIO_BIT = 0;
    localparam int CFG_DAC_BIT = 2;
    localparam logic [7:0] CFG_WRITABLE_MASK = 8'h05;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    localparam logic [7:0] FIRST_KEY = 8'h76;
    localparam logic [7:0] SECOND_KEY = 8'hb1;

    // exception vector window that the remap swaps
    localparam logic [31:0] VECTOR_LO_ADDR = 32'h00000000;
    localparam logic [31:0] VECTOR_HI_ADDR = 32'h00000020;
    localparam logic [31:0] USER_RESET_VECTOR = 32'h00000000;

    // cycles spent in the configuration routine before the branch
    localparam int CONFIG_CYCLES = 16;

    typedef enum logic [1:0] {
        BOOT_HOLD = 2'b00,
        BOOT_CONFIG = 2'b01,
        BOOT_RUN = 2'b11,
        BOOT_KERNEL = 2'b10
    } rsm_boot_type;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_ARMED = 2'b01,
        KEY_PENDING = 2'b11
    } rsm_key_type;
endpackage

// ---- rsm_cfg_if.sv ----
// carrier between the register front end and the retention key sequencer
`timescale 1ns/100ps
`default_nettype none
interface rsm_cfg_if;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] cfg;
    modport front (output wr, output addr, output wdata, input cfg);
    modport keyer (input wr, input addr, input wdata, output cfg);
endinterface
`default_nettype wire

// ---- rsm_key_seq.sv ----
// key-protected retention configuration register
`timescale 1ns/100ps
`default_nettype none
module rsm_key_seq (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    rsm_cfg_if.keyer bus
);
    import rsm_pkg::*;

    typedef struct packed {
        rsm_key_type st;
        logic [7:0] pend;
        logic [7:0] cfg;
    } rsm_key_state_type;

    rsm_key_state_type q;
    rsm_key_state_type d;

    logic hit_first;
    logic hit_cfg;
    logic hit_second;

    assign hit_first = bus.wr && (bus.addr == UNLOCK_FIRST_ADDR);
    assign hit_cfg = bus.wr && (bus.addr == RETAIN_CFG_ADDR);
    assign hit_second = bus.wr && (bus.addr == UNLOCK_SECOND_ADDR);
    assign bus.cfg = q.cfg;

    always_comb begin
        d = q;
        // only the three writes of the sequence move it; other registers do not disturb it
        case (q.st)
            KEY_IDLE: begin
                if (hit_first && bus.wdata == FIRST_KEY) begin
                    d.st = KEY_ARMED;
                end
            end
            KEY_ARMED: begin
                if (hit_cfg) begin
                    d.st = KEY_PENDING;
                    d.pend = bus.wdata & CFG_WRITABLE_MASK;
                end else if (hit_second || (hit_first && bus.wdata != FIRST_KEY)) begin
                    d.st = KEY_IDLE;
                end
            end
            KEY_PENDING: begin
                if (hit_second && bus.wdata == SECOND_KEY) begin
                    d.cfg = q.pend;
                    d.st = KEY_IDLE;
                end else if (hit_first && bus.wdata == FIRST_KEY) begin
                    d.st = KEY_ARMED;
                end else if (hit_first || hit_cfg || hit_second) begin
                    d.st = KEY_IDLE;
                end
            end
            default: begin
                d.st = KEY_IDLE;
            end
        endcase
    end

    // only power-on clears the configuration, so it survives watchdog and software resets
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q.st <= KEY_IDLE;
            q.pend <= CFG_RESET_VAL;
            q.cfg <= CFG_RESET_VAL;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ---- rsm_top_assertions.sv ----
// concurrent checks on the reset status and memory remap ports
`timescale 1ns/100ps
`default_nettype none
module rsm_top_assertions (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic ext_reset_in,
    input wire logic wdt_timeout_in,
    input wire logic [31:0] cpu_addr_in,
    input wire logic soft_reset_req_out,
    input wire logic core_hold_out,
    input wire logic kernel_mode_out,
    input wire logic mirror_sram_out,
    input wire logic vector_from_sram_out,
    input wire logic [1:0] debug_pin_function_out,
    input wire logic gpio_retain_out,
    input wire logic dac_retain_out,
    input wire logic gpio_reset_out,
    input wire logic dac_reset_out
);
    import rsm_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    logic map_wr;
    logic evt;
    assign map_wr = reg_wr_in && reg_addr_in == MAP_SEL_ADDR;
    // a reset event in the same cycle overrides a remap write
    assign evt = ext_reset_in || wdt_timeout_in || soft_reset_req_out;
    property p_soft; reg_wr_in && reg_addr_in == CAUSE_STATUS_ADDR && reg_wdata_in[2]
        |=> soft_reset_req_out; endproperty
    a_soft: assert property (p_soft) else $error("soft request missing");
    property p_set; map_wr && reg_wdata_in[0] && !evt |=> mirror_sram_out; endproperty
    a_set: assert property (p_set) else $error("remap not set");
    property p_clr; map_wr && !reg_wdata_in[0] |=> !mirror_sram_out; endproperty
    a_clr: assert property (p_clr) else $error("remap not cleared");
    property p_evt; ext_reset_in || wdt_timeout_in |=> !mirror_sram_out; endproperty
    a_evt: assert property (p_evt) else $error("remap kept over reset");
    property p_vec; vector_from_sram_out ==
        (mirror_sram_out && $past(cpu_addr_in) <= VECTOR_HI_ADDR); endproperty
    a_vec: assert property (p_vec) else $error("vector window wrong");
    property p_pin; debug_pin_function_out != 2'h1 && debug_pin_function_out != 2'h3; endproperty
    a_pin: assert property (p_pin) else $error("pin function code");
    property p_krn; kernel_mode_out |-> core_hold_out; endproperty
    a_krn: assert property (p_krn) else $error("core released in kernel");
    property p_gkeep; wdt_timeout_in && gpio_retain_out |=> !gpio_reset_out; endproperty
    a_gkeep: assert property (p_gkeep) else $error("gpio not kept");
    property p_dkeep; wdt_timeout_in && dac_retain_out |=> !dac_reset_out; endproperty
    a_dkeep: assert property (p_dkeep) else $error("dac not kept");
    property p_ext; ext_reset_in |=> gpio_reset_out && dac_reset_out; endproperty
    a_ext: assert property (p_ext) else $error("no peripheral reset");
endmodule
`default_nettype wire

// ---- rsm_core_model.sv ----
// core and reset generator stand-in: reset cause pulses and fetch addresses
`timescale 1ns/100ps
`default_nettype none
module rsm_core_model (
    input wire logic clk_in,
    input wire logic wdt_req_in,
    input wire logic ext_req_in,
    output logic wdt_timeout_out,
    output logic ext_reset_out,
    output logic [31:0] cpu_addr_out
);
    logic wdt_seen = 1'h0;
    logic ext_seen = 1'h0;
    initial begin
        wdt_timeout_out = 1'h0;
        ext_reset_out = 1'h0;
        cpu_addr_out = 32'h0;
    end
    // each toggle of a request becomes one cycle of that reset cause
    always @(posedge clk_in) begin
        wdt_timeout_out <= wdt_req_in ^ wdt_seen;
        ext_reset_out <= ext_req_in ^ ext_seen;
        wdt_seen <= wdt_req_in;
        ext_seen <= ext_req_in;
        // fetches sweep across the top of the vector window and past it
        cpu_addr_out <= (cpu_addr_out + 32'h4) & 32'h3f;
    end
endmodule
`default_nettype wire

// ---- test_reset_status_and_memory_remap.sv ----
// self-checking bench of the reset status and memory remap block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_reset_status_and_memory_remap;
    import rsm_pkg::*;
    logic ref_clk_in = 1'h0, rstn_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
    logic [31:0] reg_addr_in = 32'h0, reg_wdata_in = 32'h0, reg_rdata_out, cpu_addr_in;
    logic boot_mode_pin_in = 1'h1, boot_strap_pin_in = 1'h1;
    logic flash_reduced_in = 1'h1, sram_reduced_in = 1'h0, wdt_req = 1'h0, ext_req = 1'h0;
    logic ext_reset_in, wdt_timeout_in, soft_reset_req_out, core_hold_out, kernel_mode_out;
    logic mirror_sram_out, gpio_retain_out, dac_retain_out, gpio_reset_out, dac_reset_out;
    logic [1:0] debug_pin_function_out;
    logic [31:0] boot_vector_out;
    int mismatches = 0;
    int num_checks = 0;
    // short boot routine keeps each restart to a handful of cycles
    rsm_top #(.CONFIG_LEN(2)) u_rsm_top (.ref_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ext_reset_in, .wdt_timeout_in,
        .boot_mode_pin_in, .boot_strap_pin_in, .flash_reduced_in, .sram_reduced_in,
        .cpu_addr_in, .soft_reset_req_out, .core_hold_out, .kernel_mode_out,
        .boot_vector_out, .mirror_sram_out, .vector_from_sram_out(), .debug_pin_function_out,
        .gpio_retain_out, .dac_retain_out, .gpio_reset_out, .dac_reset_out);
    rsm_core_model u_rsm_core_model (.clk_in(ref_clk_in), .wdt_req_in(wdt_req),
        .ext_req_in(ext_req), .wdt_timeout_out(wdt_timeout_in),
        .ext_reset_out(ext_reset_in), .cpu_addr_out(cpu_addr_in));
    task automatic end_of_test;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= {24'h0, d};
        reg_wr_in <= 1'h1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'h0;
        #1;
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'h0;
        #1;
        `CHK(nm, e, reg_rdata_out)
    endtask
    // kernel mode never releases the core, so the wait is bounded
    task automatic settle;
        repeat (4) @(posedge ref_clk_in);
        repeat (40) begin
            @(posedge ref_clk_in);
            #1;
            if (core_hold_out === 1'h0) break;
        end
    endtask
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        settle();
        `CHK("core_hold", 1'h0, core_hold_out)
        `CHK("boot_vector", 32'h0, boot_vector_out)
        rd("status", CAUSE_STATUS_ADDR, 32'h1);
        rd("map", MAP_SEL_ADDR, 32'h14);
        rd("cfg", RETAIN_CFG_ADDR, 32'h0);
        wr(CAUSE_CLEAR_ADDR, 8'h07);
        rd("status", CAUSE_STATUS_ADDR, 32'h0);
        wr(MAP_SEL_ADDR, 8'hff);
        `CHK("mirror", 1'h1, mirror_sram_out)
        rd("map", MAP_SEL_ADDR, 32'h15);
        rd("key", UNLOCK_FIRST_ADDR, 32'h0);
        rd("hole", 32'hffff0240, 32'h0);
        wr(MAP_SEL_ADDR, 8'h00);
        `CHK("mirror", 1'h0, mirror_sram_out)
        wr(RETAIN_CFG_ADDR, 8'h05);
        rd("cfg", RETAIN_CFG_ADDR, 32'h0);
        wr(UNLOCK_FIRST_ADDR, FIRST_KEY);
        wr(RETAIN_CFG_ADDR, 8'h05);
        wr(UNLOCK_SECOND_ADDR, SECOND_KEY);
        rd("cfg", RETAIN_CFG_ADDR, 32'h5);
        `CHK("gpio_keep", 1'h1, gpio_retain_out)
        `CHK("dac_keep", 1'h1, dac_retain_out)
        wr(MAP_SEL_ADDR, 8'h01);
        @(posedge ref_clk_in) wdt_req <= ~wdt_req;
        settle();
        `CHK("mirror", 1'h0, mirror_sram_out)
        rd("status", CAUSE_STATUS_ADDR, 32'h2);
        wr(CAUSE_STATUS_ADDR, 8'h04);
        `CHK("soft_req", 1'h1, soft_reset_req_out)
        settle();
        rd("status", CAUSE_STATUS_ADDR, 32'h6);
        wr(CAUSE_CLEAR_ADDR, 8'h02);
        rd("status", CAUSE_STATUS_ADDR, 32'h4);
        wr(CAUSE_CLEAR_ADDR, 8'h07);
        @(posedge ref_clk_in);
        boot_mode_pin_in <= 1'h0;
        boot_strap_pin_in <= 1'h0;
        sram_reduced_in <= 1'h1;
        ext_req <= ~ext_req;
        settle();
        `CHK("kernel", 1'h1, kernel_mode_out)
        `CHK("core_hold", 1'h1, core_hold_out)
        rd("status", CAUSE_STATUS_ADDR, 32'h0);
        rd("map", MAP_SEL_ADDR, 32'h18);
        rd("cfg", RETAIN_CFG_ADDR, 32'h5);
        end_of_test();
    end
endmodule
bind rsm_top rsm_top_assertions u_rsm_top_assertions (.ref_clk_in, .rstn_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .ext_reset_in, .wdt_timeout_in, .cpu_addr_in,
    .soft_reset_req_out, .core_hold_out, .kernel_mode_out, .mirror_sram_out,
    .vector_from_sram_out, .debug_pin_function_out, .gpio_retain_out, .dac_retain_out,
    .gpio_reset_out, .dac_reset_out);
`default_nettype wire
